// ### hw/osh_device.sv
// Device end: receives bytes over 4-wire SPI or I2C and steers them to command or display data.
// Assumes all link pins are asynchronous to core_clk and the serial clock is far slower than it.
// Overview of operation
// - Strap low picks SPI, high I2C
// - Initialization runs while init reset low
// - Host keeps init reset high normally
// - Communication accepted only while select low
// - Data/command high: bytes are display data
// - Data/command low: bytes go to commands
// - I2C: data/command pin is address bit
// - SPI: data pin input, clock pin input
// - I2C: data pin bidirectional, clock input
`timescale 1ns/1ps
module osh_device
   import osh_pkg::*;
#(
   parameter logic [5:0] ADDR_HIGH = osh_pkg::ADDR_HIGH_DEF
) (
   input  wire logic   core_clk,
   input  wire logic   reset_n,
   osh_link_if.dev     link,
   output logic        init_active_r,
   output logic        byte_valid_r,
   output logic [osh_pkg::BYTE_BITS-1:0] byte_data_r,
   output logic        byte_is_data_r,
   output logic        i2c_mode_r
);
   import osh_pkg::*;
   typedef enum {I_IDLE, I_RX, I_ACK, I_SKIP} osh_istate_t;

   localparam int NSYNC = 6;
   localparam int NEDGE = 2;
   // Reset levels are the idle pins with init held, so reset leaves no false edge or early run
   localparam logic [NSYNC-1:0] SYNC_IDLE = 6'h0b;
   logic [NSYNC-1:0] s1_r;
   logic [NSYNC-1:0] s2_r;
   logic [NEDGE-1:0] s3_r;
   logic             strap;
   logic             init_n;
   logic             sel_n;
   logic             dc;
   logic             scl;
   logic             sda;
   logic             scl_rise;
   logic             scl_fall;
   logic             sda_rise;
   logic             sda_fall;
   logic             run;

   // Two flops on every pin; the third stage is only for edge finding
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s1_r <= SYNC_IDLE;
         s2_r <= SYNC_IDLE;
         s3_r <= SYNC_IDLE[NEDGE-1:0];
      end else begin
         s1_r <= {link.link_type_strap, link.init_reset_n, link.dev_select_n,
                  link.data_command_select, link.serial_clock_pin, link.serial_data_pin};
         s2_r <= s1_r;
         s3_r <= s2_r[NEDGE-1:0];
      end
   end

   assign {strap, init_n, sel_n, dc, scl, sda} = s2_r;
   // One edge finder per serial pin; bit 1 is the clock, bit 0 the data
   logic [NEDGE-1:0] pin_rise;
   logic [NEDGE-1:0] pin_fall;
   for (genvar g = 0; g < NEDGE; g++) begin : g_edge
      assign pin_rise[g] = s2_r[g] && !s3_r[g];
      assign pin_fall[g] = !s2_r[g] && s3_r[g];
   end
   assign scl_rise = pin_rise[1];
   assign scl_fall = pin_fall[1];
   assign sda_rise = pin_rise[0];
   assign sda_fall = pin_fall[0];
   // Held in initialization while the reset pin is low
   assign run      = !init_active_r && !sel_n;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         init_active_r <= 1'b1;
         i2c_mode_r    <= 1'b0;
      end else begin
         init_active_r <= !init_n;
         i2c_mode_r    <= (strap == STRAP_I2C);
      end
   end

   // SPI receiver
   // Dropping select clears the count, so a cut frame leaves no stale bits
   logic [BYTE_BITS-1:0] spi_sh_r;
   logic [2:0]           spi_cnt_r;
   logic                 spi_done;

   assign spi_done = run && !i2c_mode_r && scl_rise && (spi_cnt_r == 3'(BYTE_BITS - 1));

   always_ff @(posedge core_clk) begin
      if (!reset_n || !run || i2c_mode_r) begin
         spi_sh_r  <= '0;
         spi_cnt_r <= 3'h0;
      end else if (scl_rise) begin
         spi_sh_r  <= {spi_sh_r[BYTE_BITS-2:0], sda};
         spi_cnt_r <= spi_cnt_r + 3'h1;
      end
   end

   // I2C receiver; a byte counts 8 rising edges, the ninth slot is the acknowledge
   osh_istate_t          ist_r;
   osh_phase_t           ph_r;
   logic [BYTE_BITS-1:0] i2c_sh_r;
   logic [3:0]           i2c_cnt_r;
   logic                 i2c_dc_r;
   logic                 ack_r;
   logic                 i2c_done;
   logic                 addr_hit;

   logic                 data_done;

   // Data and control bytes are always taken; the address byte only on a match
   function automatic logic ack_wanted(input osh_phase_t ph, input logic hit);
      return (ph != PH_ADDR) || hit;
   endfunction : ack_wanted

   assign addr_hit  = (i2c_sh_r[BYTE_BITS-1:1] == {ADDR_HIGH, dc}) && (i2c_sh_r[0] == RW_WRITE);
   assign i2c_done  = (ist_r == I_RX) && scl_fall && (i2c_cnt_r == 4'(BYTE_BITS));
   assign data_done = i2c_done && (ph_r == PH_DATA);

   always_ff @(posedge core_clk) begin
      if (!reset_n || !run || !i2c_mode_r) begin
         ist_r     <= I_IDLE;
         ph_r      <= PH_ADDR;
         i2c_sh_r  <= '0;
         i2c_cnt_r <= 4'h0;
      end else if (scl && sda_fall) begin
         ist_r     <= I_RX;
         ph_r      <= PH_ADDR;
         i2c_cnt_r <= 4'h0;
      end else if (scl && sda_rise) begin
         ist_r <= I_IDLE;
      end else begin
         case (ist_r)
            I_RX: begin
               if (scl_rise) begin
                  i2c_sh_r  <= {i2c_sh_r[BYTE_BITS-2:0], sda};
                  i2c_cnt_r <= i2c_cnt_r + 4'h1;
               end else if (i2c_done) begin
                  // Reads and foreign addresses are left unacknowledged
                  ist_r <= ack_wanted(ph_r, addr_hit) ? I_ACK : I_SKIP;
                  ph_r  <= (ph_r == PH_ADDR) ? PH_CTRL : PH_DATA;
               end
            end
            I_ACK: begin
               if (scl_fall) begin
                  i2c_cnt_r <= 4'h0;
                  ist_r     <= I_RX;
               end
            end
            I_SKIP: ist_r <= I_SKIP;
            default: ist_r <= I_IDLE;
         endcase
      end
   end

   // The control byte picks data or command for every byte after it in the frame
   always_ff @(posedge core_clk) begin
      if (!reset_n || !run || !i2c_mode_r) begin
         i2c_dc_r <= 1'b0;
      end else if (i2c_done && (ph_r == PH_CTRL)) begin
         i2c_dc_r <= i2c_sh_r[CTRL_DC_BIT];
      end
   end

   // Acknowledge drive: set at the fall that ends a byte, dropped at the next fall
   always_ff @(posedge core_clk) begin
      if (!reset_n || !run || !i2c_mode_r) begin
         ack_r <= 1'b0;
      end else if (scl && (sda_fall || sda_rise)) begin
         ack_r <= 1'b0;
      end else if (i2c_done) begin
         ack_r <= ack_wanted(ph_r, addr_hit);
      end else if ((ist_r == I_ACK) && scl_fall) begin
         ack_r <= 1'b0;
      end
   end

   // Open drain: only ever pulls the line low during an acknowledge
   assign link.sda_dev_out = 1'b0;
   assign link.sda_dev_oe  = ack_r;

   // Byte steering to command register or display memory
   // Both kinds leave on the same strobe; only the flag tells them apart
   always_ff @(posedge core_clk) begin
      if (!reset_n || init_active_r) begin
         byte_valid_r   <= 1'b0;
         byte_data_r    <= '0;
         byte_is_data_r <= 1'b0;
      end else begin
         byte_valid_r <= spi_done || data_done;
         if (spi_done) begin
            byte_data_r    <= {spi_sh_r[BYTE_BITS-2:0], sda};
            byte_is_data_r <= dc;
         end else if (data_done) begin
            byte_data_r    <= i2c_sh_r;
            byte_is_data_r <= i2c_dc_r;
         end
      end
   end
endmodule : osh_device

// ### hw/osh_pkg.sv
// Shared constants for the serial host interface: link selection, byte layout, bit timing.
// Assumes a single 100 MHz core clock in both ends.
package osh_pkg;
   localparam int        CORE_CLK_NS   = 10;
   localparam int        BYTE_BITS     = 8;
   localparam int        I2C_SLOT_BITS = 9;
   localparam int        I2C_FRAME     = 3 * I2C_SLOT_BITS;
   localparam logic      STRAP_SPI     = 1'b0;
   localparam logic      STRAP_I2C     = 1'b1;
   localparam logic      RW_WRITE      = 1'b0;
   localparam int        CTRL_DC_BIT   = 6;
   localparam logic [5:0] ADDR_HIGH_DEF = 6'h1e;
   // Least half periods of the serial clock, in ns, rounded up to core cycles
   localparam int        SPI_HALF_NS   = 50;
   localparam int        I2C_HALF_NS   = 1250;
   localparam int        SPI_HALF_CYC  = (SPI_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int        I2C_HALF_CYC  = (I2C_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   typedef enum logic [1:0] {PH_ADDR, PH_CTRL, PH_DATA} osh_phase_t;
endpackage : osh_pkg

// ### hw/osh_link_if.sv
// Pins between host and display interface.
// Serial data is open drain with a pull-up in I2C and push-pull from the host in SPI; the level is resolved here from both enables.
`timescale 1ns/1ps
interface osh_link_if;
   logic link_type_strap;
   logic init_reset_n;
   logic dev_select_n;
   logic data_command_select;
   logic serial_clock_pin;
   logic sda_host_out;
   logic sda_host_oe;
   logic sda_dev_out;
   logic sda_dev_oe;
   logic serial_data_pin;

   assign serial_data_pin = (sda_host_oe ? sda_host_out : 1'b1) & (sda_dev_oe ? sda_dev_out : 1'b1);

   modport host (
      output link_type_strap,
      output init_reset_n,
      output dev_select_n,
      output data_command_select,
      output serial_clock_pin,
      output sda_host_out,
      output sda_host_oe,
      input  serial_data_pin
   );
   modport dev (
      input  link_type_strap,
      input  init_reset_n,
      input  dev_select_n,
      input  data_command_select,
      input  serial_clock_pin,
      output sda_dev_out,
      output sda_dev_oe,
      input  serial_data_pin
   );
endinterface : osh_link_if

// ### hw/osh_host.sv
// Host end: writes single bytes over 4-wire SPI or I2C, making the serial clock by a divider.
// Assumes the user holds the request fields stable while xfer_valid is high.
`timescale 1ns/1ps
module osh_host
   import osh_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   reset_n,
   input  wire logic   use_i2c,
   input  wire logic   init_req,
   input  wire logic   addr_low_bit,
   input  wire logic   xfer_valid,
   input  wire logic [osh_pkg::BYTE_BITS-1:0] xfer_data,
   input  wire logic   xfer_is_data,
   output logic        xfer_ready,
   osh_link_if.host    link
);
   import osh_pkg::*;
   typedef enum {S_IDLE, S_START, S_LO, S_HI, S_END1, S_END2, S_END3} osh_hstate_t;

   osh_hstate_t         st_r;
   logic [7:0]          div_r;
   logic                tick;
   logic [I2C_FRAME-1:0] sh_r;
   logic [4:0]          cnt_r;
   logic                scl_r;
   logic                sda_r;
   logic                cs_n_r;
   logic                dc_r;

   assign tick       = (div_r == 8'h00);
   assign xfer_ready = (st_r == S_IDLE) && tick;

   // Strap is tied by the host to the wanted link
   assign link.link_type_strap = use_i2c ? STRAP_I2C : STRAP_SPI;
   // Reset line stays high unless the user asks for initialization
   assign link.init_reset_n    = !init_req;
   assign link.dev_select_n    = cs_n_r;
   assign link.data_command_select = dc_r;
   assign link.serial_clock_pin = scl_r;
   assign link.sda_host_out    = sda_r;
   // SPI drives push-pull; I2C only pulls low
   assign link.sda_host_oe     = use_i2c ? !sda_r : 1'b1;

   always_ff @(posedge core_clk) begin
      if (!reset_n || tick) begin
         div_r <= use_i2c ? 8'(I2C_HALF_CYC - 1) : 8'(SPI_HALF_CYC - 1);
      end else begin
         div_r <= div_r - 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st_r   <= S_IDLE;
         sh_r   <= '0;
         cnt_r  <= 5'h00;
         scl_r  <= 1'b1;
         sda_r  <= 1'b1;
         cs_n_r <= 1'b1;
         dc_r   <= 1'b0;
      end else if (tick) begin
         case (st_r)
            S_IDLE: begin
               scl_r <= use_i2c;
               sda_r <= 1'b1;
               if (xfer_valid) begin
                  cs_n_r <= 1'b0;
                  // SPI carries data/command on the pin; I2C puts the address bit there
                  dc_r   <= use_i2c ? addr_low_bit : xfer_is_data;
                  if (use_i2c) begin
                     sh_r  <= {ADDR_HIGH_DEF, addr_low_bit, RW_WRITE, 1'b1,
                               1'b0, xfer_is_data, 6'h00, 1'b1, xfer_data, 1'b1};
                     cnt_r <= 5'(I2C_FRAME);
                     st_r  <= S_START;
                  end else begin
                     sh_r  <= {xfer_data, {(I2C_FRAME-BYTE_BITS){1'b0}}};
                     cnt_r <= 5'(BYTE_BITS);
                     st_r  <= S_LO;
                  end
               end
            end
            S_START: begin
               sda_r <= 1'b0;
               st_r  <= S_LO;
            end
            S_LO: begin
               scl_r <= 1'b0;
               sda_r <= sh_r[I2C_FRAME-1];
               st_r  <= S_HI;
            end
            S_HI: begin
               scl_r <= 1'b1;
               sh_r  <= {sh_r[I2C_FRAME-2:0], 1'b0};
               cnt_r <= cnt_r - 5'h01;
               st_r  <= (cnt_r == 5'h01) ? S_END1 : S_LO;
            end
            S_END1: begin
               scl_r <= 1'b0;
               sda_r <= 1'b0;
               st_r  <= S_END2;
            end
            S_END2: begin
               scl_r <= use_i2c;
               st_r  <= S_END3;
            end
            S_END3: begin
               sda_r  <= 1'b1;
               cs_n_r <= 1'b1;
               st_r   <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule : osh_host

// ### testbench/osh_chk.sv
// Assertions on the link pins and on the device's byte outputs.
// Assumes one core clock for both ends; placed beside the link interface.
`timescale 1ns/1ps
module osh_chk (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic link_type_strap,
   input wire logic init_reset_n,
   input wire logic dev_select_n,
   input wire logic data_command_select,
   input wire logic serial_clock_pin,
   input wire logic sda_dev_out,
   input wire logic sda_dev_oe,
   input wire logic init_active_r,
   input wire logic byte_valid_r,
   input wire logic byte_is_data_r,
   input wire logic i2c_mode_r
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Six samples leave room for the two-stage synchroniser
   a_strap_sets_mode: assert property ($stable(link_type_strap) [*6] |-> i2c_mode_r == link_type_strap)
      else $error("mode differs from strap");
   a_init_while_low: assert property (!init_reset_n [*5] |-> init_active_r)
      else $error("init not active");
   a_init_ends_high: assert property (init_reset_n [*6] |-> !init_active_r)
      else $error("init stuck active");
   a_no_byte_init: assert property (byte_valid_r |-> !init_active_r && !$past(init_active_r, 4))
      else $error("byte during init");
   a_select_gates: assert property (byte_valid_r |-> !$past(dev_select_n, 4))
      else $error("byte while deselected");
   a_dc_steers: assert property (byte_valid_r && !i2c_mode_r |-> byte_is_data_r == $past(data_command_select, 4))
      else $error("data/command steering wrong");
   a_spi_no_drive: assert property (!i2c_mode_r |-> !sda_dev_oe)
      else $error("device drives data pin in SPI");
   a_ack_pulls_low: assert property (sda_dev_oe |-> !sda_dev_out && i2c_mode_r && !dev_select_n)
      else $error("device drives data pin outside an acknowledge");
   a_ack_on_byte: assert property (byte_valid_r && i2c_mode_r |-> sda_dev_oe)
      else $error("data byte not acknowledged");
   a_ack_clock_low: assert property ($changed(sda_dev_oe) |-> !serial_clock_pin)
      else $error("ack changes while clock high");
   c_spi_data: cover property (byte_valid_r && byte_is_data_r && !i2c_mode_r);
   c_spi_cmd: cover property (byte_valid_r && !byte_is_data_r && !i2c_mode_r);
   c_i2c_byte: cover property (byte_valid_r && i2c_mode_r);
   c_i2c_ack: cover property ($rose(sda_dev_oe));
endmodule : osh_chk

// ### testbench/oled_serial_host_interface_tb.sv
// Host and device ends joined by the link; bytes sent by the host are checked at the device.
// Assumes the host makes the serial clock itself.
`timescale 1ns/1ps
module oled_serial_host_interface_tb;
   import osh_pkg::*;
   logic        core_clk, reset_n, use_i2c, init_req, addr_low_bit, xfer_valid, xfer_is_data, xfer_ready;
   logic        init_active_r, byte_valid_r, byte_is_data_r, i2c_mode_r;
   logic [7:0]  xfer_data, byte_data_r, wire_sh;
   logic [8:0]  exp_e;
   logic [8:0]  exp_q[$];
   logic [31:0] lfsr;
   int          n_mismatch, compares;

   osh_link_if i_osh_link_if ();
   osh_host i_osh_host (.core_clk(core_clk), .reset_n(reset_n), .use_i2c(use_i2c), .init_req(init_req),
      .addr_low_bit(addr_low_bit), .xfer_valid(xfer_valid), .xfer_data(xfer_data), .xfer_is_data(xfer_is_data),
      .xfer_ready(xfer_ready), .link(i_osh_link_if));
   osh_device i_osh_device (.core_clk(core_clk), .reset_n(reset_n), .link(i_osh_link_if),
      .init_active_r(init_active_r), .byte_valid_r(byte_valid_r), .byte_data_r(byte_data_r),
      .byte_is_data_r(byte_is_data_r), .i2c_mode_r(i2c_mode_r));
   osh_chk i_osh_chk (.core_clk(core_clk), .reset_n(reset_n), .link_type_strap(i_osh_link_if.link_type_strap),
      .init_reset_n(i_osh_link_if.init_reset_n), .dev_select_n(i_osh_link_if.dev_select_n),
      .data_command_select(i_osh_link_if.data_command_select), .serial_clock_pin(i_osh_link_if.serial_clock_pin),
      .sda_dev_out(i_osh_link_if.sda_dev_out), .sda_dev_oe(i_osh_link_if.sda_dev_oe),
      .init_active_r(init_active_r), .byte_valid_r(byte_valid_r), .byte_is_data_r(byte_is_data_r),
      .i2c_mode_r(i2c_mode_r));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim();
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   // Ready is combinational, so it is looked at mid-cycle
   task automatic wait_ready();
      int n;
      n = 0;
      @(negedge core_clk);
      while (xfer_ready !== 1'b1 && n < 20000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 20000) begin
         n_mismatch++;
         end_sim();
      end
   endtask : wait_ready

   task automatic send(input logic [7:0] d, input logic is_d, input logic shows);
      @(posedge core_clk);
      #1 xfer_data = d;
      xfer_is_data = is_d;
      xfer_valid = 1'b1;
      wait_ready();
      @(posedge core_clk);
      if (shows)
         exp_q.push_back({is_d, d});
      #1 xfer_valid = 1'b0;
   endtask : send

   task automatic drain();
      wait_ready();
      chk(9'(exp_q.size()), 9'h000);
   endtask : drain

   // Bits as they cross the wire, to check order independently of the device
   always @(posedge i_osh_link_if.serial_clock_pin) begin
      if (i_osh_link_if.dev_select_n === 1'b0)
         wire_sh <= {wire_sh[6:0], i_osh_link_if.serial_data_pin};
   end

   // Looked at mid-cycle, clear of the edge that launches the strobe
   always @(negedge core_clk) begin
      if (byte_valid_r === 1'b1) begin
         exp_e = 'x;
         if (exp_q.size() != 0)
            exp_e = exp_q.pop_front();
         chk({byte_is_data_r, byte_data_r}, exp_e);
         if (i2c_mode_r === 1'b0)
            chk({1'b0, wire_sh}, {1'b0, exp_e[7:0]});
      end
   end

   initial begin
      repeat (80000) @(posedge core_clk);
      n_mismatch++;
      end_sim();
   end

   initial begin
      reset_n = 1'b0;
      use_i2c = STRAP_SPI;
      init_req = 1'b0;
      addr_low_bit = 1'b0;
      xfer_valid = 1'b0;
      xfer_data = 8'h00;
      xfer_is_data = 1'b0;
      n_mismatch = 0;
      compares = 0;
      lfsr = 32'hc32f;
      repeat (16) @(posedge core_clk);
      #1 reset_n = 1'b1;
      repeat (8) @(posedge core_clk);
      chk({8'h00, i2c_mode_r}, {8'h00, STRAP_SPI});
      chk({8'h00, init_active_r}, 9'h000);
      // Byte extremes, then random back-to-back bytes of both kinds
      send(8'h00, 1'b0, 1'b1);
      send(8'hff, 1'b1, 1'b1);
      for (int i = 0; i < 16; i++) begin
         lfsr = lfsr_next(lfsr);
         send(lfsr[7:0], lfsr[8], 1'b1);
      end
      drain();
      // A byte sent during initialization must vanish
      @(posedge core_clk);
      #1 init_req = 1'b1;
      repeat (8) @(posedge core_clk);
      chk({8'h00, init_active_r}, 9'h001);
      send(8'h5a, 1'b1, 1'b0);
      drain();
      @(posedge core_clk);
      #1 init_req = 1'b0;
      repeat (8) @(posedge core_clk);
      chk({8'h00, init_active_r}, 9'h000);
      send(8'ha5, 1'b0, 1'b1);
      drain();
      @(posedge core_clk);
      #1 use_i2c = STRAP_I2C;
      repeat (8) @(posedge core_clk);
      chk({8'h00, i2c_mode_r}, {8'h00, STRAP_I2C});
      // Address bit and byte kind walk all four pairs; frames are slow, so only a few
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         @(posedge core_clk);
         #1 addr_low_bit = i[0];
         send(lfsr[7:0], i[1], 1'b1);
         drain();
      end
      @(posedge core_clk);
      #1 use_i2c = STRAP_SPI;
      repeat (8) @(posedge core_clk);
      send(8'h3c, 1'b1, 1'b1);
      drain();
      end_sim();
   end
endmodule : oled_serial_host_interface_tb
